// ==== pkg/pmic_status_regs.vh ====
// Register offsets, bit positions, reset values and timing counts for the
// status and rail fault-flag register bank. Definitions only.
// Behaviour
// - Status bit 7 follows input-at-monitor level, rising about 10 us late.
// - Status bit 6 follows input-at-warning level, rising about 10 us late.
// - Status bit 5 follows input power-ok-high, rising about 10 us late.
// - Status bit 4 follows input overvoltage, rising about 10 us late.
// - Status bit 3 shows thermal warning comparator live, never latched.
// - Status bit 2 shows thermal shutdown comparator live, never latched.
// - Status bit 1 is 1 with power good, 0 when power bad.
// - Status register at 0x00 is read-only, resets to 0, ignores writes.
// - Undervoltage flags at 0x01: bucks 1-4 in bits 7-4, regulators in 3-2.
// - Overvoltage flags at 0x02 use the same bit order as undervoltage.
// - Undervoltage flag sets on an event and holds until cleared.
// - Overvoltage flag sets on an event and holds until cleared.
// - Reading a flag returns it, then clears it to 0 unless its event is still present.
// - Flag bits 1 and 0 are reserved, reset and read as 0.
// - Registers reached over the register port; invalid during supply lockout.
`ifndef PMIC_STATUS_REGS_VH
`define PMIC_STATUS_REGS_VH

// Register offsets
`define OFS_INPUT_THERMAL_LIVE_STATUS 8'h00
`define OFS_RAIL_UNDERVOLTAGE_FLAGS   8'h01
`define OFS_RAIL_OVERVOLTAGE_FLAGS    8'h02

// Reset values
`define RST_INPUT_THERMAL_LIVE_STATUS 8'h00
`define RST_RAIL_UNDERVOLTAGE_FLAGS   8'h00
`define RST_RAIL_OVERVOLTAGE_FLAGS    8'h00

// Status register bit positions
`define BIT_INPUT_MONITOR_OK      7
`define BIT_INPUT_WARNING_OK      6
`define BIT_INPUT_POK_HIGH        5
`define BIT_INPUT_OVERVOLTAGE     4
`define BIT_THERMAL_WARNING       3
`define BIT_THERMAL_SHUTDOWN_LVL  2
`define BIT_POWER_GOOD_STATE      1
`define BIT_FAULT_PRESENT         0

// Rail flag field: six rails in bits 7..2, bits 1..0 reserved
`define RAIL_COUNT     6
`define RAIL_FIELD_LSB 2

// Timing
`define CLK_PERIOD_PS    8000
`define INPUT_RISE_DLY_PS 10000000
`define INPUT_RISE_CYCLES \
  ((`INPUT_RISE_DLY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== hdl/level_qualifier.v ====
// Synchronises one comparator level and, when asked, delays its rising
// edge by a fixed count of clock cycles; falling edges pass at once.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module level_qualifier #(
  parameter integer DELAY_CYCLES = 0
) (
  // Clock and reset
  input  wire clk,
  input  wire arst_n,
  // Level in and qualified level out
  input  wire levelIn,
  output wire levelOut
);

  reg        syncA_reg;
  reg        syncB_reg;
  reg        out_reg;
  reg [11:0] count_reg;
  reg [11:0] count_next;
  reg        out_next;

  localparam [11:0] LAST = (DELAY_CYCLES > 0) ?
                           DELAY_CYCLES[11:0] - 12'h001 : 12'h000;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      out_reg   <= 1'b0;
      count_reg <= 12'h000;
    end else begin
      syncA_reg <= levelIn;
      syncB_reg <= syncA_reg;
      out_reg   <= out_next;
      count_reg <= count_next;
    end
  end

  // Count while high; raise the output once the count completes
  always @* begin
    count_next = 12'h000;
    out_next   = 1'b0;
    if (syncB_reg) begin
      if (DELAY_CYCLES == 0 || out_reg) begin
        out_next = 1'b1;
      end else if (count_reg == LAST) begin
        out_next = 1'b1;
      end else begin
        count_next = count_reg + 12'h001;
      end
    end
  end

  assign levelOut = out_reg;

endmodule // level_qualifier
`default_nettype wire

// ==== hdl/pmic_status_fault_flags.v ====
// Status and rail fault-flag register bank of a multi-rail power device.
// Assumes comparator and power-good levels arrive asynchronously, and that
// register reads and writes come as one-cycle strobes on clk.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_status_regs.vh"
module pmic_status_fault_flags (
  // Clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // Register port
  input  wire       regRead,
  input  wire       regWrite,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  output wire [7:0] regRdData,
  output wire       regAck,
  // Input supply comparators
  input  wire       inputMonitorOk,
  input  wire       inputWarningOk,
  input  wire       inputPokHigh,
  input  wire       inputOvervoltage,
  // Die temperature comparators
  input  wire       thermalWarning,
  input  wire       thermalShutdownLevel,
  // Sequencer state and analog supply lockout
  input  wire       powerGoodState,
  input  wire       analogSupplyInput,
  // Rail events, bucks 1..4 in bits 5..2, regulators 1..2 in bits 1..0
  input  wire [5:0] railUndervolt,
  input  wire [5:0] railOvervolt,
  // Fault summary
  output wire       faultPresent
);

  localparam integer RISE_CYCLES = `INPUT_RISE_CYCLES;

  // Places a six-rail field in bits 7..2, reserved bits at 0
  function [7:0] railField;
    input [5:0] rails;
    begin
      railField = {rails, 2'b00};
    end
  endfunction

  wire       monitorQ;
  wire       warningQ;
  wire       pokHighQ;
  wire       overvoltQ;
  wire       thermWarnQ;
  wire       thermShutQ;
  wire       powerGoodQ;
  wire       supplyOkQ;
  wire [5:0] uvQ;
  wire [5:0] ovQ;

  // Input supply bits with delayed rise
  level_qualifier #(.DELAY_CYCLES(RISE_CYCLES)) uMonitor (
    .clk(clk), .arst_n(arst_n), .levelIn(inputMonitorOk),
    .levelOut(monitorQ));
  level_qualifier #(.DELAY_CYCLES(RISE_CYCLES)) uWarning (
    .clk(clk), .arst_n(arst_n), .levelIn(inputWarningOk),
    .levelOut(warningQ));
  level_qualifier #(.DELAY_CYCLES(RISE_CYCLES)) uPokHigh (
    .clk(clk), .arst_n(arst_n), .levelIn(inputPokHigh),
    .levelOut(pokHighQ));
  level_qualifier #(.DELAY_CYCLES(RISE_CYCLES)) uOvervolt (
    .clk(clk), .arst_n(arst_n), .levelIn(inputOvervoltage),
    .levelOut(overvoltQ));

  // Live levels, synchronised only
  level_qualifier #(.DELAY_CYCLES(0)) uThermWarn (
    .clk(clk), .arst_n(arst_n), .levelIn(thermalWarning),
    .levelOut(thermWarnQ));
  level_qualifier #(.DELAY_CYCLES(0)) uThermShut (
    .clk(clk), .arst_n(arst_n), .levelIn(thermalShutdownLevel),
    .levelOut(thermShutQ));
  level_qualifier #(.DELAY_CYCLES(0)) uPowerGood (
    .clk(clk), .arst_n(arst_n), .levelIn(powerGoodState),
    .levelOut(powerGoodQ));
  level_qualifier #(.DELAY_CYCLES(0)) uSupplyOk (
    .clk(clk), .arst_n(arst_n), .levelIn(analogSupplyInput),
    .levelOut(supplyOkQ));

  genvar g;
  generate
    for (g = 0; g < `RAIL_COUNT; g = g + 1) begin : gRail
      level_qualifier #(.DELAY_CYCLES(0)) uUv (
        .clk(clk), .arst_n(arst_n), .levelIn(railUndervolt[g]),
        .levelOut(uvQ[g]));
      level_qualifier #(.DELAY_CYCLES(0)) uOv (
        .clk(clk), .arst_n(arst_n), .levelIn(railOvervolt[g]),
        .levelOut(ovQ[g]));
    end
  endgenerate

  reg [7:0] status_reg;
  reg [7:0] status_next;
  reg [5:0] uvFlags_reg;
  reg [5:0] uvFlags_next;
  reg [5:0] ovFlags_reg;
  reg [5:0] ovFlags_next;
  reg [7:0] rdData_reg;
  reg [7:0] rdData_next;
  reg       ack_reg;

  wire readUv = regRead && (regAddr == `OFS_RAIL_UNDERVOLTAGE_FLAGS);
  wire readOv = regRead && (regAddr == `OFS_RAIL_OVERVOLTAGE_FLAGS);
  wire anyFault = (|uvFlags_reg) || (|ovFlags_reg) || thermShutQ;

  // Live status word; held at reset value during supply lockout
  always @* begin
    status_next = `RST_INPUT_THERMAL_LIVE_STATUS;
    if (supplyOkQ) begin
      status_next[`BIT_INPUT_MONITOR_OK]     = monitorQ;
      status_next[`BIT_INPUT_WARNING_OK]     = warningQ;
      status_next[`BIT_INPUT_POK_HIGH]       = pokHighQ;
      status_next[`BIT_INPUT_OVERVOLTAGE]    = overvoltQ;
      status_next[`BIT_THERMAL_WARNING]      = thermWarnQ;
      status_next[`BIT_THERMAL_SHUTDOWN_LVL] = thermShutQ;
      status_next[`BIT_POWER_GOOD_STATE]     = powerGoodQ;
      status_next[`BIT_FAULT_PRESENT]        = anyFault;
    end
  end

  // Sticky flags: a read clears, but an event in the same cycle wins
  always @* begin
    uvFlags_next = uvFlags_reg;
    ovFlags_next = ovFlags_reg;
    if (readUv) begin
      uvFlags_next = 6'h00;
    end
    if (readOv) begin
      ovFlags_next = 6'h00;
    end
    uvFlags_next = uvFlags_next | uvQ;
    ovFlags_next = ovFlags_next | ovQ;
    if (!supplyOkQ) begin
      uvFlags_next = 6'h00;
      ovFlags_next = 6'h00;
    end
  end

  // Read mux; writes change nothing, unmapped reads return zero
  always @* begin
    rdData_next = rdData_reg;
    if (regRead) begin
      case (regAddr)
        `OFS_INPUT_THERMAL_LIVE_STATUS: rdData_next = status_reg;
        `OFS_RAIL_UNDERVOLTAGE_FLAGS:
          rdData_next = railField(uvFlags_reg);
        `OFS_RAIL_OVERVOLTAGE_FLAGS:
          rdData_next = railField(ovFlags_reg);
        default: rdData_next = 8'h00;
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg  <= `RST_INPUT_THERMAL_LIVE_STATUS;
      uvFlags_reg <= 6'h00;
      ovFlags_reg <= 6'h00;
      rdData_reg  <= 8'h00;
      ack_reg     <= 1'b0;
    end else begin
      status_reg  <= status_next;
      uvFlags_reg <= uvFlags_next;
      ovFlags_reg <= ovFlags_next;
      rdData_reg  <= rdData_next;
      ack_reg     <= regRead || regWrite;
    end
  end

  // Write data is accepted and dropped: every register here is read-only
  wire unusedWrite = ^regWrData;

  assign regRdData    = rdData_reg;
  assign regAck       = ack_reg & ~(unusedWrite & 1'b0);
  assign faultPresent = status_reg[`BIT_FAULT_PRESENT];

endmodule // pmic_status_fault_flags
`default_nettype wire

// ==== verif/pmic_status_checker.sv ====
// Concurrent checks on the status and rail flag register bank.
// Assumes it is bound to pmic_status_fault_flags.
`timescale 1ns/1ps
`default_nettype none
module pmic_status_checker (
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       regRead,
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic       regAck,
  // Levels and events
  input wire logic       thermalWarning,
  input wire logic       thermalShutdownLevel,
  input wire logic       analogSupplyInput,
  input wire logic [5:0] railUndervolt,
  input wire logic [5:0] railOvervolt,
  input wire logic       faultPresent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ack_pulse_a: assert property (regAck == $past(regRead || regWrite))
    else $error("ack not one cycle after request");
  rsvd_zero_a: assert property (regRead && regAddr != 8'h00 |=>
    regRdData[1:0] == 2'b00) else $error("reserved flag bits set");
  uv_clear_a: assert property ((railUndervolt == 6'h00)[*8] ##0
    (regRead && regAddr == 8'h01 && $past(regRead && regAddr == 8'h01, 2))
    |=> regRdData == 8'h00) else $error("undervolt flags not cleared");
  ov_clear_a: assert property ((railOvervolt == 6'h00)[*8] ##0
    (regRead && regAddr == 8'h02 && $past(regRead && regAddr == 8'h02, 2))
    |=> regRdData == 8'h00) else $error("overvolt flags not cleared");
  lockout_a: assert property ((!analogSupplyInput)[*8] ##0 regRead
    |=> regRdData == 8'h00) else $error("data during supply lockout");
  thermal_live_a: assert property (
    (thermalWarning && analogSupplyInput)[*8]
    ##0 (regRead && regAddr == 8'h00) |=> regRdData[3])
    else $error("thermal warning bit low");
  fault_rail_a: assert property (
    (railOvervolt[0] && analogSupplyInput)[*8] |-> faultPresent)
    else $error("fault missing after rail event");
  fault_temp_a: assert property (
    (thermalShutdownLevel && analogSupplyInput)[*8] |-> faultPresent)
    else $error("fault missing in shutdown");
  rd_hold_a: assert property (!regRead |=> $stable(regRdData))
    else $error("read data moved without a read");
endmodule // pmic_status_checker
`default_nettype wire

// ==== verif/reg_host_model.sv ====
// Host side of the register port: one strobed access at a time.
// Assumes the answer arrives exactly one edge after the request.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  // Clock
  input  wire logic       clk,
  // Register port, host side
  output var  logic       regRead,
  output var  logic       regWrite,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regAck
);
  initial begin
    {regRead, regWrite, regAddr, regWrData} = 18'h0_0000;
  end
  // Reads consume the flags, so every read result is passed back
  task automatic xfer(input logic wr, input logic [7:0] a, d,
                      output logic [7:0] q, output logic ok);
    {regRead, regWrite, regAddr, regWrData} = {!wr, wr, a, d};
    @(posedge clk);
    #1;
    {regRead, regWrite, regAddr, regWrData} = {2'b00, ~a, ~d};
    @(posedge clk);
    q = regRdData;
    ok = regAck;
    #1;
  endtask
endmodule // reg_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the status and rail flag register bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, arst_n, regRead, regWrite, regAck, faultPresent, ok;
  logic [7:0] regAddr, regWrData, regRdData, q;
  logic [3:0] inp;
  logic       thermalWarning, thermalShutdownLevel, powerGoodState;
  logic       analogSupplyInput;
  logic [5:0] railUndervolt, railOvervolt, p;
  logic [2:0] r;
  int         failures, n_tests;

  pmic_status_fault_flags dut (
    .clk, .arst_n, .regRead, .regWrite, .regAddr, .regWrData, .regRdData,
    .regAck, .inputMonitorOk(inp[3]), .inputWarningOk(inp[2]),
    .inputPokHigh(inp[1]), .inputOvervoltage(inp[0]), .thermalWarning,
    .thermalShutdownLevel, .powerGoodState, .analogSupplyInput,
    .railUndervolt, .railOvervolt, .faultPresent
  );
  reg_host_model host (
    .clk, .regRead, .regWrite, .regAddr, .regWrData, .regRdData, .regAck
  );

  function automatic logic [7:0] st(logic [3:0] m, logic [2:0] t);
    return {m, t, t[1]};
  endfunction
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (e !== s) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q, ok);
    cmp("regAck", 8'h01, {7'h00, ok});
    cmp("regRdData", e, q);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h0000_03c4));
    {arst_n, inp, analogSupplyInput, railUndervolt, railOvervolt} = 18'h0;
    {thermalWarning, thermalShutdownLevel, powerGoodState} = 3'b111;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    cyc(8);
    for (int a = 0; a < 4; a++) rd(8'(a), 8'h00);
    analogSupplyInput = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 3'b111 : (i == 1) ? 3'b000 : 3'($urandom);
      {thermalWarning, thermalShutdownLevel, powerGoodState} = r;
      cyc(8);
      rd(8'h00, st(4'h0, r));
    end
    {thermalWarning, thermalShutdownLevel, powerGoodState} = 3'b001;
    host.xfer(1'b1, 8'h00, 8'hff, q, ok);
    cmp("regAck", 8'h01, {7'h00, ok});
    inp = 4'hf;
    cyc(1200);
    rd(8'h00, st(4'h0, 3'b001));
    cyc(60);
    rd(8'h00, st(4'hf, 3'b001));
    inp = 4'h7;
    cyc(8);
    rd(8'h00, st(4'h7, 3'b001));
    for (int i = 0; i < 12; i++) begin
      p = (i < 6) ? 6'(1 << i) : 6'($urandom);
      {railUndervolt, railOvervolt} = {p, ~p};
      cyc(3);
      {railUndervolt, railOvervolt} = 12'h000;
      cyc(8);
      cmp("faultPresent", 8'h01, {7'h00, faultPresent});
      rd(8'h01, {p, 2'b00});
      rd(8'h01, 8'h00);
      rd(8'h02, {~p, 2'b00});
      rd(8'h02, 8'h00);
    end
    cyc(4);
    cmp("faultPresent", 8'h00, {7'h00, faultPresent});
    railOvervolt = 6'h01;
    cyc(8);
    rd(8'h02, 8'h04);
    rd(8'h02, 8'h04);
    railOvervolt = 6'h00;
    cyc(8);
    rd(8'h02, 8'h04);
    rd(8'h02, 8'h00);
    // Mid-run reset clears a set flag and restarts the rise delay
    railOvervolt = 6'h01;
    cyc(8);
    cmp("faultPresent", 8'h01, {7'h00, faultPresent});
    {arst_n, railOvervolt} = 7'h00;
    cyc(3);
    arst_n = 1'b1;
    cyc(8);
    cmp("faultPresent", 8'h00, {7'h00, faultPresent});
    rd(8'h02, 8'h00);
    rd(8'h00, st(4'h0, 3'b001));
    analogSupplyInput = 1'b0;
    cyc(8);
    rd(8'h00, 8'h00);
    end_sim;
  end
endmodule // tb_top

bind pmic_status_fault_flags pmic_status_checker chk (
  .clk, .arst_n, .regRead, .regWrite, .regAddr, .regRdData, .regAck,
  .thermalWarning, .thermalShutdownLevel, .analogSupplyInput,
  .railUndervolt, .railOvervolt, .faultPresent
);
`default_nettype wire
